// File: hw/monitor_cal_pkg.sv
/*
 Holds the constants and carrier types of the monitor result calibration block.
 Assumes a byte-wide memory port driven by the serial memory interface logic.
*/
package monitor_cal_pkg;
   // ==========================================================
   // Memory map
   localparam logic [7:0] ADDR_TEMP_MSB = 8'h60;
   localparam logic [7:0] ADDR_RES_LAST = 8'h69;
   localparam logic [7:0] ADDR_TABLE_LO = 8'h80;
   localparam logic [7:0] ADDR_SHIFT_A = 8'h8E;
   localparam logic [7:0] ADDR_SHIFT_B = 8'h8F;
   localparam logic [7:0] ADDR_GAIN_LO = 8'h92;
   localparam logic [7:0] ADDR_GAIN_HI = 8'h99;
   localparam logic [7:0] ADDR_TOFF_MSB = 8'hA0;
   localparam logic [7:0] ADDR_TOFF_LSB = 8'hA1;
   localparam logic [7:0] ADDR_OFF_LO = 8'hA2;
   localparam logic [7:0] ADDR_OFF_HI = 8'hA9;
   localparam logic [7:0] TABLE_MAIN = 8'h04;
   localparam logic [7:0] TABLE_COMPAT = 8'h01;
   // ==========================================================
   // Reset values and shift field positions
   localparam logic [15:0] GAIN_RESET = 16'h8000;
   localparam logic [15:0] OFFSET_RESET = 16'h0000;
   localparam logic [15:0] TOFF_RESET = 16'h0000;
   localparam logic [7:0] SHIFT_RESET = 8'h00;
   localparam int SHIFT_BIAS_MONITOR_INPUT_POS = 4;
   localparam int SHIFT_TX_POWER_INPUT_POS = 0;
   localparam int SHIFT_RX_POWER_INPUT_POS = 0;
   localparam int GAIN_FRAC_BITS = 15;
   // ==========================================================
   // Result limits and temperature offset coding
   localparam logic [15:0] VOLT_MAX = 16'hFFF8;
   localparam logic [15:0] TEMP_POS_FS = 16'h7FF8;
   localparam logic [15:0] TEMP_NEG_FS = 16'h8000;
   localparam logic [15:0] TOFF_XOR = 16'hBB40;
   localparam logic signed [19:0] TOFF_BIAS = 20'sh11300; // 275 degrees in 1/256 units
   localparam int NUM_CHAN = 5;
   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      CH_TEMP = 3'h0, CH_VCC = 3'h1, CH_BIAS_MONITOR_INPUT = 3'h2, CH_TX_POWER_INPUT = 3'h3, CH_RX_POWER_INPUT = 3'h4
   } chan_type;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01, ST_START = 5'h02, ST_WAIT = 5'h04, ST_CALC = 5'h08, ST_STORE = 5'h10
   } seq_state_type;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] table_sel;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mem_req_type;
endpackage

// File: hw/monitor_result_calibration.sv
/*
 Sequences conversions, calibrates results and serves the result and calibration bytes.
 Assumes converter and memory port logic run on ref_clk_in; busy covers a whole transaction.
*/
// What this block does
// - Temperature stored as 16-bit two's complement at 60h/61h, MSB first.
// - Temperature refreshed each frame, never started during a memory transaction.
// - Temperature codes limited to 7FF8 down to 8000.
// - Temperature code divided by 256 gives degrees, upper half negative.
// - Offset from the temperature offset register added to each temperature result.
// - Supply and three monitor inputs converted round-robin with 13-bit converter.
// - Voltage results 16-bit unsigned, left-justified, at 62h through 69h.
// - Full scale gives FFF8h, null gives zero, linear between.
// - Factory supply full scale 6.5528V, monitor LSB 38.147 microvolts.
// - Supply and each monitor input own gain and offset registers; only the monitor inputs have shift fields.
// - Each monitor channel shifts results right by a 3-bit count.
// - Calibration registers live in table 04h or 01h per compatibility mode.
// - Right shift is the last step after gain and offset.
// - Temperature uses only its offset register, no gain.
`timescale 1ns/1ps
module monitor_result_calibration
   import monitor_cal_pkg::*;
#(
   parameter int ADC_BITS = 13
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire mem_req_type mem_req_in,
   input wire logic mem_busy_in,
   input wire logic compat_mode_in,
   input wire logic conv_done_in,
   input wire logic [ADC_BITS-1:0] adc_data_in,
   input wire logic [15:0] temp_data_in,
   output logic [7:0] mem_rdata_out,
   output logic conv_start_out,
   output logic [2:0] conv_chan_out,
   output logic frame_done_out
);
   initial begin
      if (ADC_BITS != 13) begin
         $error("ADC_BITS must be 13");
      end
   end

   // ==========================================================
   // Calibration and result storage
   logic [15:0] gain [4];
   logic [15:0] offset [4];
   logic [15:0] temp_offset;
   logic [7:0] shift_count_reg_a;
   logic [7:0] shift_count_reg_b;
   logic [15:0] result [NUM_CHAN];
   logic [7:0] rdata;
   logic [15:0] next_gain [4];
   logic [15:0] next_offset [4];
   logic [15:0] next_temp_offset;
   logic [7:0] next_shift_a;
   logic [7:0] next_shift_b;
   logic [15:0] next_result [NUM_CHAN];
   logic [7:0] next_rdata;
   logic [7:0] cal_table;
   logic cal_hit;
   logic [7:0] a;
   logic [1:0] gidx;
   logic [1:0] oidx;
   logic [2:0] ridx;

   seq_state_type state;
   seq_state_type next_state;
   logic [2:0] chan;
   logic [2:0] next_chan;
   logic [15:0] raw;
   logic [15:0] next_raw;
   logic [15:0] calc;
   logic [15:0] next_calc;
   logic start;
   logic next_start;
   logic frame_done;
   logic next_frame_done;

   assign cal_table = compat_mode_in ? TABLE_COMPAT : TABLE_MAIN;
   assign a = mem_req_in.addr;
   assign cal_hit = (a >= ADDR_TABLE_LO) && (mem_req_in.table_sel == cal_table);
   assign gidx = 2'((a - ADDR_GAIN_LO) >> 1);
   assign oidx = 2'((a - ADDR_OFF_LO) >> 1);
   assign ridx = 3'((a - ADDR_TEMP_MSB) >> 1);

   // ==========================================================
   // Register writes, result stores and byte reads
   always_comb begin
      next_gain = gain;
      next_offset = offset;
      next_temp_offset = temp_offset;
      next_shift_a = shift_count_reg_a;
      next_shift_b = shift_count_reg_b;
      next_result = result;
      next_rdata = rdata;
      if (mem_req_in.wr && cal_hit) begin
         if (a == ADDR_SHIFT_A) begin
            next_shift_a = mem_req_in.wdata;
         end else if (a == ADDR_SHIFT_B) begin
            next_shift_b = mem_req_in.wdata;
         end else if (a >= ADDR_GAIN_LO && a <= ADDR_GAIN_HI) begin
            if (a[0]) next_gain[gidx][7:0] = mem_req_in.wdata;
            else next_gain[gidx][15:8] = mem_req_in.wdata;
         end else if (a == ADDR_TOFF_MSB) begin
            next_temp_offset[15:8] = mem_req_in.wdata;
         end else if (a == ADDR_TOFF_LSB) begin
            next_temp_offset[7:0] = mem_req_in.wdata;
         end else if (a >= ADDR_OFF_LO && a <= ADDR_OFF_HI) begin
            if (a[0]) next_offset[oidx][7:0] = mem_req_in.wdata;
            else next_offset[oidx][15:8] = mem_req_in.wdata;
         end
      end
      // Whole word lands at once and only between transactions
      if (state == ST_STORE && !mem_busy_in) begin
         next_result[chan] = calc;
      end
      if (mem_req_in.rd) begin
         next_rdata = 8'h00;
         if (a >= ADDR_TEMP_MSB && a <= ADDR_RES_LAST) begin
            next_rdata = a[0] ? result[ridx][7:0] : result[ridx][15:8];
         end else if (cal_hit) begin
            if (a == ADDR_SHIFT_A) begin
               next_rdata = shift_count_reg_a;
            end else if (a == ADDR_SHIFT_B) begin
               next_rdata = shift_count_reg_b;
            end else if (a >= ADDR_GAIN_LO && a <= ADDR_GAIN_HI) begin
               next_rdata = a[0] ? gain[gidx][7:0] : gain[gidx][15:8];
            end else if (a == ADDR_TOFF_MSB) begin
               next_rdata = temp_offset[15:8];
            end else if (a == ADDR_TOFF_LSB) begin
               next_rdata = temp_offset[7:0];
            end else if (a >= ADDR_OFF_LO && a <= ADDR_OFF_HI) begin
               next_rdata = a[0] ? offset[oidx][7:0] : offset[oidx][15:8];
            end
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         for (int i = 0; i < 4; i++) begin
            gain[i] <= GAIN_RESET;
            offset[i] <= OFFSET_RESET;
         end
         for (int i = 0; i < NUM_CHAN; i++) begin
            result[i] <= 16'h0000;
         end
         temp_offset <= TOFF_RESET;
         shift_count_reg_a <= SHIFT_RESET;
         shift_count_reg_b <= SHIFT_RESET;
         rdata <= 8'h00;
      end else begin
         gain <= next_gain;
         offset <= next_offset;
         temp_offset <= next_temp_offset;
         shift_count_reg_a <= next_shift_a;
         shift_count_reg_b <= next_shift_b;
         result <= next_result;
         rdata <= next_rdata;
      end
   end

   // ==========================================================
   // Calibration arithmetic
   logic [1:0] vidx;
   logic [2:0] shift;
   logic [31:0] prod;
   logic signed [19:0] vsum;
   logic [15:0] vsat;
   logic signed [19:0] tsum;
   logic [15:0] tsat;

   assign vidx = 2'(chan - 3'(CH_VCC));

   always_comb begin
      shift = 3'h0;
      case (chan)
         CH_BIAS_MONITOR_INPUT: shift = shift_count_reg_a[SHIFT_BIAS_MONITOR_INPUT_POS +: 3];
         CH_TX_POWER_INPUT: shift = shift_count_reg_a[SHIFT_TX_POWER_INPUT_POS +: 3];
         CH_RX_POWER_INPUT: shift = shift_count_reg_b[SHIFT_RX_POWER_INPUT_POS +: 3];
         default: shift = 3'h0;
      endcase
      prod = raw * gain[vidx];
      vsum = signed'({3'b000, prod[31:GAIN_FRAC_BITS]})
         + (20'(signed'(offset[vidx])) <<< 2);
      if (vsum < 0) begin
         vsat = 16'h0000;
      end else if (vsum > signed'({4'h0, VOLT_MAX})) begin
         vsat = VOLT_MAX;
      end else begin
         vsat = vsum[15:0];
      end
      // Offset register is 64*(delta-275) XOR'd, so delta*256 = 4*decoded + 275*256
      tsum = 20'(signed'(raw)) + (20'(signed'(temp_offset ^ TOFF_XOR)) <<< 2)
         + TOFF_BIAS;
      if (tsum > 20'(signed'(TEMP_POS_FS))) begin
         tsat = TEMP_POS_FS;
      end else if (tsum < 20'(signed'(TEMP_NEG_FS))) begin
         tsat = TEMP_NEG_FS;
      end else begin
         tsat = tsum[15:0];
      end
   end

   // ==========================================================
   // Round-robin conversion sequencer
   always_comb begin
      next_state = state;
      next_chan = chan;
      next_raw = raw;
      next_calc = calc;
      next_start = 1'b0;
      next_frame_done = 1'b0;
      case (state)
         ST_IDLE: begin
            if (chan != 3'(CH_TEMP) || !mem_busy_in) begin
               next_start = 1'b1;
               next_state = ST_START;
            end
         end
         ST_START: next_state = ST_WAIT;
         ST_WAIT: begin
            if (conv_done_in) begin
               next_raw = (chan == 3'(CH_TEMP)) ? temp_data_in
                  : {adc_data_in, 3'b000};
               next_state = ST_CALC;
            end
         end
         ST_CALC: begin
            next_calc = (chan == 3'(CH_TEMP)) ? tsat : (vsat >> shift);
            next_state = ST_STORE;
         end
         ST_STORE: begin
            if (!mem_busy_in) begin
               next_state = ST_IDLE;
               if (chan == 3'(CH_RX_POWER_INPUT)) begin
                  next_chan = 3'(CH_TEMP);
                  next_frame_done = 1'b1;
               end else begin
                  next_chan = chan + 3'h1;
               end
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         state <= ST_IDLE;
         chan <= 3'h0;
         raw <= 16'h0000;
         calc <= 16'h0000;
         start <= 1'b0;
         frame_done <= 1'b0;
      end else begin
         state <= next_state;
         chan <= next_chan;
         raw <= next_raw;
         calc <= next_calc;
         start <= next_start;
         frame_done <= next_frame_done;
      end
   end

   assign mem_rdata_out = rdata;
   assign conv_start_out = start;
   assign conv_chan_out = chan;
   assign frame_done_out = frame_done;

   // ==========================================================
   // Checks
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);

   logic [2:0] last_start_chan;
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) last_start_chan <= 3'(CH_RX_POWER_INPUT);
      else if (start) last_start_chan <= chan;
   end

   a_temp_no_busy: assert property ((start && chan == 3'(CH_TEMP)) |-> $past(!mem_busy_in))
      else $error("temperature conversion started during a transaction");
   a_store_quiet: assert property ((state == ST_STORE && mem_busy_in) |=> $stable(result[chan]))
      else $error("result changed during a transaction");
   a_temp_range: assert property ((state == ST_STORE && chan == 3'(CH_TEMP) && !mem_busy_in)
      |=> (result[0] <= TEMP_POS_FS || result[0] >= TEMP_NEG_FS))
      else $error("temperature code out of range");
   a_volt_sat: assert property ((state == ST_STORE && chan != 3'(CH_TEMP)) |-> calc <= VOLT_MAX)
      else $error("voltage result above full scale");
   a_shift_last: assert property ((state == ST_STORE && chan == 3'(CH_RX_POWER_INPUT))
      |-> calc <= (VOLT_MAX >> shift_count_reg_b[SHIFT_RX_POWER_INPUT_POS +: 3]))
      else $error("shift not applied");
   a_round_robin: assert property (start |-> chan == ((last_start_chan == 3'(CH_RX_POWER_INPUT))
      ? 3'(CH_TEMP) : last_start_chan + 3'h1))
      else $error("channel order broken");
   a_msb_read: assert property ((mem_req_in.rd && a == ADDR_TEMP_MSB)
      |=> mem_rdata_out == $past(result[0][15:8]))
      else $error("temperature MSB not at 60h");
   a_table_sel: assert property ((mem_req_in.wr && a == ADDR_GAIN_LO
      && mem_req_in.table_sel != cal_table) |=> $stable(gain[0]))
      else $error("write to wrong table changed gain");
   a_calc_store: assert property ((state == ST_CALC) |=> state == ST_STORE ##1 1'b1)
      else $error("calculation not followed by store");

   c_frame: cover property (frame_done);
   c_temp_stall: cover property (state == ST_IDLE && chan == 3'(CH_TEMP) && mem_busy_in);
   c_volt_clip: cover property (state == ST_CALC && chan != 3'(CH_TEMP) && vsum > 20'sh0FFF8);
   c_shifted: cover property (state == ST_STORE && shift != 3'h0);
endmodule

// File: test/monitor_front_model.sv
/*
 Converter and temperature sensor model facing the conversion link.
 Assumes starts are one-cycle pulses on ref_clk_in; answers alternate prompt and slow.
*/
`timescale 1ns/1ps
module monitor_front_model
   import monitor_cal_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic conv_start_in,
   input wire logic [2:0] conv_chan_in,
   input wire logic [15:0] temp_level_in,
   input wire logic [3:0][12:0] volt_level_in,
   output logic conv_done_out,
   output logic [12:0] adc_data_out,
   output logic [15:0] temp_data_out,
   output int order_errors_out
);
   int wait_left = -1;
   logic slow = 1'b0;
   logic [2:0] expect_chan = 3'h0;
   logic [2:0] chan = 3'h0;
   initial begin
      conv_done_out = 1'b0;
      adc_data_out = 13'h0000;
      temp_data_out = 16'h0000;
      order_errors_out = 0;
   end
   // ====================================
   // Data lines toggle outside the done cycle; adc_data also toggles in a temperature done cycle
   always @(negedge ref_clk_in) begin
      conv_done_out <= 1'b0;
      adc_data_out <= ~adc_data_out;
      temp_data_out <= ~temp_data_out;
      if (sys_rst_in) begin
         wait_left <= -1;
         expect_chan <= 3'h0;
      end else if (conv_start_in === 1'b1) begin
         if (conv_chan_in !== expect_chan) order_errors_out <= order_errors_out + 1;
         expect_chan <= (conv_chan_in == 3'h4) ? 3'h0 : conv_chan_in + 3'h1;
         chan <= conv_chan_in;
         wait_left <= slow ? 6 : 1;
         slow <= ~slow;
      end else if (wait_left == 0) begin
         conv_done_out <= 1'b1;
         temp_data_out <= temp_level_in;
         if (chan != 3'h0) adc_data_out <= volt_level_in[chan-3'h1];
         wait_left <= -1;
      end else if (wait_left > 0) begin
         wait_left <= wait_left - 1;
      end
   end
endmodule

// File: test/monitor_result_calibration_tb.sv
/*
 Self-checking bench for the monitor result calibration block.
 Assumes the front model answers the conversion link; the bench acts as host.
*/
`timescale 1ns/1ps
module monitor_result_calibration_tb
   import monitor_cal_pkg::*;
;
   logic ref_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   mem_req_type mem_req = '0;
   logic busy = 1'b0;
   logic compat = 1'b0;
   logic conv_done, conv_start, frame_done;
   logic [12:0] adc_data;
   logic [15:0] temp_data;
   logic [7:0] rdata;
   logic [2:0] conv_chan;
   logic [15:0] temp_level = 16'h0000;
   logic [3:0][12:0] volt_level = '0;
   logic [7:0] cal;
   int order_errors;
   int n_errors = 0;
   int compares = 0;
   assign cal = compat ? TABLE_COMPAT : TABLE_MAIN;
   always #20 ref_clk_in = ~ref_clk_in;
   monitor_result_calibration #(.ADC_BITS(13)) DUT (
      .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .mem_req_in(mem_req),
      .mem_busy_in(busy), .compat_mode_in(compat), .conv_done_in(conv_done),
      .adc_data_in(adc_data), .temp_data_in(temp_data), .mem_rdata_out(rdata),
      .conv_start_out(conv_start), .conv_chan_out(conv_chan), .frame_done_out(frame_done));
   monitor_front_model model (
      .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .conv_start_in(conv_start),
      .conv_chan_in(conv_chan), .temp_level_in(temp_level), .volt_level_in(volt_level),
      .conv_done_out(conv_done), .adc_data_out(adc_data), .temp_data_out(temp_data),
      .order_errors_out(order_errors));
   // ====================================
   // Host tasks
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic mem_op(input logic w, input logic [7:0] t, a, d, output logic [7:0] q);
      @(negedge ref_clk_in);
      mem_req = '{rd: ~w, wr: w, table_sel: t, addr: a, wdata: d};
      @(negedge ref_clk_in);
      mem_req.rd = 1'b0;
      mem_req.wr = 1'b0;
      q = rdata;
   endtask
   task automatic rd_word(input logic [7:0] t, a, output logic [15:0] q);
      busy = 1'b1;
      mem_op(1'b0, t, a, 8'h00, q[15:8]);
      mem_op(1'b0, t, a + 8'h01, 8'h00, q[7:0]);
      busy = 1'b0;
   endtask
   task automatic wr_word(input logic [7:0] a, input logic [15:0] d);
      logic [7:0] q;
      mem_op(1'b1, cal, a, d[15:8], q);
      mem_op(1'b1, cal, a + 8'h01, d[7:0], q);
   endtask
   task automatic wait_frames(input int n);
      int seen = 0;
      for (int i = 0; i < 400 && seen < n; i++) begin
         @(negedge ref_clk_in);
         if (frame_done === 1'b1) seen++;
      end
      check("frame count", n[15:0], seen[15:0]);
   endtask
   // ====================================
   // Scenarios
   task automatic t_regs();
      logic [15:0] w;
      logic [7:0] b;
      rd_word(cal, ADDR_GAIN_LO, w);
      check("gain reset", GAIN_RESET, w);
      rd_word(cal, ADDR_OFF_LO, w);
      check("offset reset", OFFSET_RESET, w);
      rd_word(cal, ADDR_TOFF_MSB, w);
      check("temp offset reset", TOFF_RESET, w);
      mem_op(1'b0, cal, ADDR_SHIFT_A, 8'h00, b);
      check("shift reset", {8'h00, SHIFT_RESET}, {8'h00, b});
      mem_op(1'b0, cal, 8'h7F, 8'h00, b);
      check("unmapped read", 16'h0000, {8'h00, b});
      compat = 1'b1;
      mem_op(1'b1, TABLE_COMPAT, ADDR_GAIN_HI, 8'h5A, b);
      mem_op(1'b0, TABLE_MAIN, ADDR_GAIN_HI, 8'h00, b);
      check("wrong table read", 16'h0000, {8'h00, b});
      mem_op(1'b0, TABLE_COMPAT, ADDR_GAIN_HI, 8'h00, b);
      check("compat table read", 16'h005A, {8'h00, b});
      compat = 1'b0;
      mem_op(1'b1, TABLE_COMPAT, ADDR_GAIN_HI, 8'h00, b);
      mem_op(1'b0, TABLE_MAIN, ADDR_GAIN_HI, 8'h00, b);
      check("ignored write", 16'h005A, {8'h00, b});
      mem_op(1'b1, TABLE_MAIN, ADDR_GAIN_HI, 8'h00, b);
   endtask
   task automatic t_busy();
      int starts = 0;
      wait_frames(1);
      busy = 1'b1;
      repeat (100) begin
         @(negedge ref_clk_in);
         if (conv_start === 1'b1 && conv_chan === 3'(CH_TEMP)) starts++;
      end
      busy = 1'b0;
      check("starts while busy", 16'h0000, starts[15:0]);
      wait_frames(1);
   endtask
   task automatic t_temp();
      logic [15:0] lvl [5] = '{16'h4000, 16'hD800, 16'h4000, 16'h7FF0, 16'h8040};
      logic [15:0] off [5] = '{16'h0000, 16'h0000, 16'h00C0, 16'h00C0, 16'h0040};
      logic [15:0] exp [5] = '{16'h4000, 16'hD800, 16'h4100, 16'h7FF8, 16'h8000};
      logic [15:0] w;
      for (int i = 0; i < 5; i++) begin
         temp_level = lvl[i];
         wr_word(ADDR_TOFF_MSB, off[i]);
         wait_frames(2);
         rd_word(cal, ADDR_TEMP_MSB, w);
         check("temperature", exp[i], w);
      end
      wr_word(ADDR_TOFF_MSB, TOFF_RESET);
   endtask
   task automatic t_volt();
      logic [15:0] exp [6] = '{16'hFFF8, 16'h0800, 16'h0840, 16'h7FFC, 16'h0080, 16'h0000};
      logic [15:0] w;
      volt_level = '{13'h1FFF, 13'h0100, 13'h1000, 13'h1FFF};
      wr_word(ADDR_GAIN_LO + 8'h02, 16'h4000);
      wr_word(ADDR_OFF_LO + 8'h04, 16'h0010);
      wr_word(ADDR_OFF_LO + 8'h06, 16'h0100);
      mem_op(1'b1, cal, ADDR_SHIFT_A, 8'h30, w[7:0]);
      mem_op(1'b1, cal, ADDR_SHIFT_B, 8'h01, w[7:0]);
      for (int i = 0; i < 6; i++) begin
         if (i == 0 || i == 4) wait_frames(2);
         rd_word(cal, ADDR_TEMP_MSB + 8'h02 + 8'(2 * ((i < 4) ? i : i - 3)), w);
         check("voltage", exp[i], w);
         if (i == 3) begin
            mem_op(1'b1, cal, ADDR_SHIFT_A, 8'h70, w[7:0]);
            wr_word(ADDR_OFF_LO + 8'h04, 16'hFC00);
         end
      end
   endtask
   // ====================================
   // Run control
   task automatic report_and_stop();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #(40 * 20000);
      n_errors++;
      report_and_stop();
   end
   initial begin
      repeat (3) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      sys_rst_in = 1'b0;
      t_regs();
      t_busy();
      t_volt();
      t_temp();
      check("round robin order", 16'h0000, order_errors[15:0]);
      report_and_stop();
   end
endmodule
